// ---- verilog/msc_top.v ----
// Summary of operation
// (R1) analog channel selector one to eight
// (R2) analog reading zero-extended to 16 bits
// (R3) out-of-range analog channel selector saturates, no error
// (R4) axis bit13 flags last command rejected
// (R5) bits 12,11,10: direction, mode, profile done
// (R6) bits 7,5,4: running, position, wrap errors
// (R7) bits 3..0: index, motor off, home, limit
// (R8) axis bits 15,14,9,8,6 read zero
// (R9) reject setdir in position, target in velocity
// (R10) reject find-home on four conditions
// (R11) reject find-index: running, trigger, limit
// (R12) reject start blocked by active limit
// (R13) time breakpoint needs position, accel, distance
// (R14) position breakpoint rejects present or zero
// (R15) homing allows only listed command set
// (R16) switch bits show synchronised switch levels
// (R17) comms bits: move complete, motor running
// (R18) comms bits: last ok, hw failure, bit2 zero
// (R19) power-on flag held until reset-position
// (R20) comms bits: function error, in process
// (R21) comms bits: data pending, ready
// (R22) move complete from profile complete
// (R23) function error set before in-process clears
`timescale 1ns/100ps
`include "msc_regs.vh"
module msc_top
(
  // clock and reset
  input wire clk,
  input wire reset,
  // axi4-lite write
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // axis state from the motion core
  input wire [3:0] ax_running,
  input wire [3:0] ax_velmode,
  input wire [3:0] ax_fwd,
  input wire [3:0] ax_pcomp,
  input wire [3:0] ax_poserr,
  input wire [3:0] ax_wrap,
  input wire [3:0] ax_index,
  input wire [3:0] ax_motor_off,
  input wire [3:0] ax_homing,
  input wire [3:0] ax_lim_home_en,
  input wire [3:0] ax_trig_en,
  input wire [3:0] ax_accel_high,
  // switch pins, asynchronous
  input wire [3:0] home_sw,
  input wire [3:0] fwd_lim,
  input wire [3:0] rev_lim,
  // analog inputs, one byte each
  input wire [63:0] adc_data,
  // return data buffer and watchdog
  input wire rdb_pending,
  input wire watchdog,
  // accepted command to the motion core
  output reg cmd_go,
  output reg [7:0] cmd_op,
  output reg [1:0] cmd_axis,
  output reg [2:0] adc_sel
);
  reg [1:0] st_q;
  reg [31:0] arg_q;
  reg [7:0] op_q;
  reg [1:0] axis_q;
  reg [3:0] nexec_q;
  reg lastok_q;
  reg ferr_q;
  reg pwron_q;
  reg hwfail_q;
  reg [15:0] adcval_q;
  reg [3:0] ctl_dir_q;
  reg [3:0] hs1_q, hs2_q, fl1_q, fl2_q, rl1_q, rl2_q;
  reg aw_got_q, w_got_q;
  reg [7:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [31:0] pos_q [0:3];
  reg [31:0] cmdarg_q;
  reg rej;
  reg ferr;
  reg [3:0] msel;
  reg [15:0] axstat [0:3];
  reg [15:0] csr;
  integer i;
  integer j;
  localparam ST_IDLE = 2'd0;
  localparam ST_EVAL = 2'd1;
  localparam ST_DONE = 2'd2;

  function [2:0] clamp_ch;
    input [31:0] v;
    begin
      if (v < `MSC_ADC_MIN)
        clamp_ch = 3'd0;
      else if (v > `MSC_ADC_MAX)
        clamp_ch = 3'd7;
      else
        clamp_ch = v[2:0] - 3'd1;
    end
  endfunction

  function allowed_homing;
    input [7:0] op;
    begin
      allowed_homing = (op >= `MSC_OP_KILL) && (op <= `MSC_OP_GPIO);
    end
  endfunction

  // switch synchronisers
  always @(posedge clk)
  begin
    hs1_q <= home_sw;
    hs2_q <= hs1_q;
    fl1_q <= fwd_lim;
    fl2_q <= fl1_q;
    rl1_q <= rev_lim;
    rl2_q <= rl1_q;
  end

  // axis status words
  always @*
  begin
    for (i = 0; i < 4; i = i + 1)
    begin
      axstat[i] = 16'h0000; // (R8)
      axstat[i][`MSC_AS_NEXEC] = nexec_q[i]; // (R4)
      axstat[i][`MSC_AS_DIR] = ax_velmode[i] & ax_fwd[i]; // (R5)
      axstat[i][`MSC_AS_VEL] = ax_velmode[i]; // (R5)
      axstat[i][`MSC_AS_PCOMP] = ax_pcomp[i]; // (R5)
      axstat[i][`MSC_AS_RUN] = ax_running[i]; // (R6)
      axstat[i][`MSC_AS_POSERR] = ax_poserr[i]; // (R6)
      axstat[i][`MSC_AS_WRAP] = ax_wrap[i]; // (R6)
      axstat[i][`MSC_AS_INDEX] = ax_index[i]; // (R7)
      axstat[i][`MSC_AS_MOFF] = ax_motor_off[i]; // (R7)
      axstat[i][`MSC_AS_HOME] = hs2_q[i]; // (R16)
      axstat[i][`MSC_AS_LIM] = fl2_q[i] | rl2_q[i]; // (R16)
    end
  end

  // comms status word
  always @*
  begin
    csr = 16'h0000;
    csr[15:12] = ax_pcomp; // (R17) (R22)
    csr[11:8] = ax_running; // (R17)
    csr[`MSC_CS_LASTOK] = lastok_q; // (R18)
    csr[`MSC_CS_HWFAIL] = hwfail_q; // (R18)
    csr[`MSC_CS_PWRON] = pwron_q; // (R19)
    csr[`MSC_CS_FERR] = ferr_q; // (R20)
    csr[`MSC_CS_INPROC] = (st_q != ST_IDLE); // (R20)
    csr[`MSC_CS_DPEND] = rdb_pending; // (R21)
    csr[`MSC_CS_READY] = (st_q == ST_IDLE); // (R21)
  end

  // command validity check
  always @*
  begin
    rej = 1'b0;
    ferr = 1'b0;
    msel = arg_q[3:0];
    if ((|ax_homing) && !allowed_homing(op_q))
      rej = 1'b1; // (R15)
    else
      case (op_q)
        `MSC_OP_SETDIR:
          rej = !ax_velmode[axis_q]; // (R9)
        `MSC_OP_LDTARGET:
          rej = ax_velmode[axis_q]; // (R9)
        `MSC_OP_FINDHOME:
          rej = ax_homing[axis_q] | !ax_lim_home_en[axis_q] |
                (|ax_trig_en) | (fl2_q[axis_q] & rl2_q[axis_q]); // (R10)
        `MSC_OP_FINDINDEX:
          rej = ax_running[axis_q] | (|ax_trig_en) |
                fl2_q[axis_q] | rl2_q[axis_q]; // (R11)
        `MSC_OP_START:
          rej = ctl_dir_q[axis_q] ? fl2_q[axis_q] : rl2_q[axis_q]; // (R12)
        `MSC_OP_MSTART:
        begin
          ferr = (msel == 4'h0) || ((msel & (msel - 4'h1)) == 4'h0);
          rej = |(msel & ((ctl_dir_q & fl2_q) | (~ctl_dir_q & rl2_q))); // (R12)
        end
        `MSC_OP_BPTIME:
          rej = ax_velmode[axis_q] | ax_accel_high[axis_q] |
                (arg_q < `MSC_MIN_DIST); // (R13)
        `MSC_OP_BPPOS:
          rej = arg_q[31] ? (arg_q[30:0] == 31'h00000000) :
                ({1'b0, arg_q[30:0]} == pos_q[axis_q]); // (R14)
        `MSC_OP_KILL, `MSC_OP_STOP, `MSC_OP_STOPMODE, `MSC_OP_RDSTAT,
        `MSC_OP_RDPOS, `MSC_OP_RDVEL, `MSC_OP_IO, `MSC_OP_LIMIT,
        `MSC_OP_ADC, `MSC_OP_GPIO, `MSC_OP_RSTPOS, `MSC_OP_SETMODE:
          rej = 1'b0;
        default:
          ferr = 1'b1;
      endcase
  end

  // axi handshake
  assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
  assign s_axi_wready = !w_got_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // command engine and bus slave
  always @(posedge clk)
  begin
    if (reset)
    begin
      st_q <= ST_IDLE;
      arg_q <= 32'h00000000;
      op_q <= 8'h00;
      axis_q <= 2'h0;
      nexec_q <= 4'h0;
      lastok_q <= 1'b1;
      ferr_q <= 1'b0;
      pwron_q <= 1'b1; // (R19)
      hwfail_q <= 1'b0;
      adcval_q <= 16'h0000;
      ctl_dir_q <= 4'hF;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      cmdarg_q <= 32'h00000000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MSC_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `MSC_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      cmd_go <= 1'b0;
      cmd_op <= 8'h00;
      cmd_axis <= 2'h0;
      adc_sel <= 3'd0;
      for (j = 0; j < 4; j = j + 1)
        pos_q[j] <= 32'h00000000;
    end
    else
    begin
      cmd_go <= 1'b0;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (aw_got_q && w_got_q)
      begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `MSC_RESP_OKAY;
        case (awaddr_q)
          `MSC_A_CMD:
            if (st_q == ST_IDLE)
            begin
              op_q <= wdata_q[7:0];
              axis_q <= wdata_q[9:8];
              arg_q <= cmdarg_q;
              st_q <= ST_EVAL;
            end
          `MSC_A_CTRL:
            cmdarg_q <= wdata_q;
          `MSC_A_HWFAIL:
            hwfail_q <= wdata_q[0];
          default:
            s_axi_bresp <= `MSC_RESP_SLV;
        endcase
      end
      case (st_q)
        // idle: a command write above moves on to evaluation
        ST_IDLE:
        begin
        end
        ST_EVAL:
        begin
          ferr_q <= ferr; // (R23)
          lastok_q <= !(rej | ferr); // (R18)
          st_q <= ST_DONE;
          if (op_q != `MSC_OP_MSTART)
            nexec_q[axis_q] <= rej; // (R4)
          else if (!ferr)
            for (j = 0; j < 4; j = j + 1)
              if (msel[j])
                nexec_q[j] <= rej;
          if (!(rej | ferr))
          begin
            cmd_go <= 1'b1;
            cmd_op <= op_q;
            cmd_axis <= axis_q;
            if (op_q == `MSC_OP_SETDIR)
              ctl_dir_q[axis_q] <= arg_q[0];
            if (op_q == `MSC_OP_RSTPOS)
            begin
              pwron_q <= 1'b0; // (R19)
              pos_q[axis_q] <= 32'h00000000;
            end
            if (op_q == `MSC_OP_ADC)
            begin
              adc_sel <= clamp_ch(arg_q); // (R1) (R3)
              adcval_q <= {8'h00,
                adc_data[clamp_ch(arg_q)*8 +: 8]}; // (R2)
            end
          end
        end
        ST_DONE:
          st_q <= ST_IDLE;
        default:
          st_q <= ST_IDLE;
      endcase
      // watchdog set wins over a reset-position clear
      if (watchdog)
        pwron_q <= 1'b1; // (R19)
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `MSC_RESP_OKAY;
        s_axi_rdata <= 32'h00000000;
        case (s_axi_araddr)
          `MSC_A_CSR:
            s_axi_rdata <= {16'h0000, csr};
          `MSC_A_ADC:
            s_axi_rdata <= {16'h0000, adcval_q};
          `MSC_A_CTRL:
            s_axi_rdata <= cmdarg_q;
          `MSC_A_HWFAIL:
            s_axi_rdata <= {31'h00000000, hwfail_q};
          8'h10, 8'h14, 8'h18, 8'h1C:
            s_axi_rdata <= {16'h0000, axstat[s_axi_araddr[3:2]]};
          default:
            s_axi_rresp <= `MSC_RESP_SLV;
        endcase
      end
    end
  end
endmodule // msc_top

// ---- inc/msc_regs.vh ----
`ifndef MSC_REGS_VH
`define MSC_REGS_VH
// register byte addresses
`define MSC_A_CMD      8'h00
`define MSC_A_CSR      8'h04
`define MSC_A_AXSTAT0  8'h10
`define MSC_A_ADC      8'h20
`define MSC_A_CTRL     8'h24
`define MSC_A_HWFAIL   8'h28
// axis status bits
`define MSC_AS_NEXEC   13
`define MSC_AS_DIR     12
`define MSC_AS_VEL     11
`define MSC_AS_PCOMP   10
`define MSC_AS_RUN     7
`define MSC_AS_POSERR  5
`define MSC_AS_WRAP    4
`define MSC_AS_INDEX   3
`define MSC_AS_MOFF    2
`define MSC_AS_HOME    1
`define MSC_AS_LIM     0
// comms status bits
`define MSC_CS_LASTOK  7
`define MSC_CS_HWFAIL  6
`define MSC_CS_PWRON   5
`define MSC_CS_FERR    4
`define MSC_CS_INPROC  3
`define MSC_CS_DPEND   1
`define MSC_CS_READY   0
// command opcodes, cmd register bits 7:0
`define MSC_OP_KILL      8'h01
`define MSC_OP_STOP      8'h02
`define MSC_OP_STOPMODE  8'h03
`define MSC_OP_RDSTAT    8'h04
`define MSC_OP_RDPOS     8'h05
`define MSC_OP_RDVEL     8'h06
`define MSC_OP_IO        8'h07
`define MSC_OP_LIMIT     8'h08
`define MSC_OP_ADC       8'h09
`define MSC_OP_GPIO      8'h0A
`define MSC_OP_SETDIR    8'h10
`define MSC_OP_LDTARGET  8'h11
`define MSC_OP_FINDHOME  8'h12
`define MSC_OP_FINDINDEX 8'h13
`define MSC_OP_START     8'h14
`define MSC_OP_MSTART    8'h15
`define MSC_OP_BPTIME    8'h16
`define MSC_OP_BPPOS     8'h17
`define MSC_OP_RSTPOS    8'h18
`define MSC_OP_SETMODE   8'h19
// analog channel range, minimum breakpoint distance, bus responses
`define MSC_ADC_MIN    3'd1
`define MSC_ADC_MAX    4'd8
`define MSC_MIN_DIST   32'h00000020
`define MSC_RESP_OKAY  2'h0
`define MSC_RESP_SLV   2'h2
`endif

// ---- tb/msc_monitor.sv ----
`timescale 1ns/100ps
`include "msc_regs.vh"
module msc_monitor
(
  // clock and reset
  input wire clk,
  input wire reset,
  // bus
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_bvalid,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  // core
  input wire [3:0] ax_running,
  input wire [3:0] ax_pcomp,
  input wire [3:0] ax_velmode,
  input wire [3:0] ax_homing,
  input wire cmd_go,
  input wire [7:0] cmd_op,
  input wire [1:0] cmd_axis
);
  logic [7:0] addr_q;
  logic [7:0] mv;
  logic csr;
  logic axs;
  // address of the read under way
  always @(posedge clk)
  begin
    if (s_axi_arvalid && s_axi_arready)
      addr_q <= s_axi_araddr;
  end
  assign mv = {ax_pcomp, ax_running};
  assign csr = s_axi_rvalid && addr_q == `MSC_A_CSR;
  assign axs = s_axi_rvalid && addr_q[7:4] == 4'h1;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_go_pulse: assert property (cmd_go |=> !cmd_go)
    else $error("cmd_go longer than one cycle");
  a_go_after_write: assert property (cmd_go |-> $past(s_axi_bvalid) ||
    $past(s_axi_bvalid, 2) || $past(s_axi_bvalid, 3))
    else $error("cmd_go without a write response");
  a_axis_zero_bits: assert property (axs |->
    s_axi_rdata[31:14] == 18'h0 && s_axi_rdata[9:8] == 2'h0
    && !s_axi_rdata[6]) else $error("unused axis bits set");
  a_csr_unused: assert property (csr |->
    !s_axi_rdata[2] && s_axi_rdata[31:16] == 16'h0)
    else $error("unused status bits set");
  a_ready_busy: assert property (csr |->
    s_axi_rdata[0] != s_axi_rdata[3]) else $error("ready equals in process");
  a_csr_motion: assert property (csr && mv == $past(mv) &&
    mv == $past(mv, 2) && mv == $past(mv, 3) |-> s_axi_rdata[15:8] == mv)
    else $error("move bits differ from core");
  a_homing_safe: assert property (cmd_go && |ax_homing &&
    ax_homing == $past(ax_homing, 3) |-> cmd_op <= `MSC_OP_GPIO)
    else $error("command accepted while homing");
  a_setdir_mode: assert property (cmd_go && cmd_op == `MSC_OP_SETDIR &&
    ax_velmode == $past(ax_velmode, 3) |-> ax_velmode[cmd_axis])
    else $error("direction accepted in position mode");
  c_go: cover property (cmd_go);
  c_csr: cover property (csr);
  c_axis: cover property (axs);
endmodule // msc_monitor

bind msc_top msc_monitor msc_monitor_inst (.clk, .reset, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_bvalid, .s_axi_rdata, .s_axi_rvalid,
  .ax_running, .ax_pcomp, .ax_velmode, .ax_homing, .cmd_go, .cmd_op,
  .cmd_axis);

// ---- tb/msc_host.sv ----
`timescale 1ns/100ps
module msc_host
(
  // clock
  input wire clk,
  // write channels
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  output logic s_axi_bready,
  // read channels
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  output logic s_axi_rready
);
  // ready lines stay high, answers are taken at once
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_bready, s_axi_rready} = {9'h0, 2'h3};
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    output logic [1:0] r);
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      do
      begin
        @(posedge clk);
        if (s_axi_awready) s_axi_awvalid <= 1'h0;
        if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end
      while (!s_axi_bvalid);
      r = s_axi_bresp;
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      do
      begin
        @(posedge clk);
        if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end
      while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
    end
  endtask
endmodule // msc_host

// ---- tb/msc_top_tb.sv ----
`timescale 1ns/100ps
`include "msc_regs.vh"
module msc_top_tb;
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic [7:0] s_axi_awaddr, s_axi_araddr, cmd_op;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp, cmd_axis;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, rdb_pending, watchdog, cmd_go;
  logic [3:0] ax_running, ax_velmode, ax_fwd, ax_pcomp, ax_poserr, ax_wrap;
  logic [3:0] ax_index, ax_motor_off, ax_homing, ax_lim_home_en, ax_trig_en;
  logic [3:0] ax_accel_high, home_sw, fwd_lim, rev_lim;
  logic [63:0] adc_data = 64'hF0E1D2C3B4A59687;
  logic [2:0] adc_sel;
  int error_cnt = 0;
  int cmp_count = 0;
  always #10 clk = ~clk;
  msc_top msc_top_inst (.clk, .reset, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .ax_running, .ax_velmode, .ax_fwd, .ax_pcomp, .ax_poserr,
    .ax_wrap, .ax_index, .ax_motor_off, .ax_homing, .ax_lim_home_en,
    .ax_trig_en, .ax_accel_high, .home_sw, .fwd_lim, .rev_lim, .adc_data,
    .rdb_pending, .watchdog, .cmd_go, .cmd_op, .cmd_axis, .adc_sel);
  msc_host msc_host_inst (.clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  task automatic conclude();
    if (error_cnt == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // read a register, compare the masked bits
  task automatic rc(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e);
    msc_host_inst.rd(a, rv, rsp);
    chk(rv & m, e);
  endtask
  // argument, command, then poll until ready
  task automatic cmd(input logic [7:0] op, input logic [1:0] ax,
    input logic [31:0] arg);
    begin
      msc_host_inst.wr(`MSC_A_CTRL, arg, rsp);
      msc_host_inst.wr(`MSC_A_CMD, {22'h0, ax, op}, rsp);
      do
        msc_host_inst.rd(`MSC_A_CSR, rv, rsp);
      while (rv[`MSC_CS_READY] !== 1'h1);
    end
  endtask
  task automatic t_stat();
    {ax_running, ax_velmode, ax_pcomp, ax_poserr} <= {4{4'h8}};
    {ax_wrap, ax_index, ax_motor_off} <= {3{4'h8}};
    repeat (2) @(posedge clk);
    rc(8'h1C, 32'hFFFFCFFF, 32'h00000CBC);
    rc(`MSC_A_CSR, 32'h0000FF00, 32'h00008800);
  endtask
  task automatic t_adc();
    cmd(`MSC_OP_ADC, 2'h0, 32'h0);
    rc(`MSC_A_ADC, 32'hFFFFFFFF, 32'h00000087);
    cmd(`MSC_OP_ADC, 2'h0, 32'h3);
    rc(`MSC_A_ADC, 32'hFFFFFFFF, 32'h000000A5);
    chk({29'h0, adc_sel}, 32'h2);
    chk({22'h0, cmd_axis, cmd_op}, {24'h0, `MSC_OP_ADC});
    cmd(`MSC_OP_ADC, 2'h0, 32'hFFFFFFFF);
    rc(`MSC_A_ADC, 32'hFFFFFFFF, 32'h000000F0);
  endtask
  task automatic t_mode();
    cmd(`MSC_OP_SETDIR, 2'h0, 32'h1);
    rc(8'h10, 32'h2000, 32'h2000);
    ax_velmode <= 4'h9;
    cmd(`MSC_OP_SETDIR, 2'h0, 32'h1);
    rc(8'h10, 32'h2000, 32'h0);
    cmd(`MSC_OP_LDTARGET, 2'h0, 32'h5);
    rc(8'h10, 32'h2000, 32'h2000);
    ax_homing <= 4'h2;
    cmd(`MSC_OP_RDSTAT, 2'h0, 32'h0);
    rc(8'h10, 32'h2000, 32'h0);
    cmd(`MSC_OP_START, 2'h0, 32'h0);
    rc(8'h10, 32'h2000, 32'h2000);
    ax_homing <= 4'h0;
  endtask
  task automatic t_switch();
    fwd_lim <= 4'h4;
    home_sw <= 4'h4;
    repeat (3) @(posedge clk);
    rc(8'h18, 32'h3, 32'h3);
    cmd(`MSC_OP_FINDINDEX, 2'h2, 32'h0);
    rc(8'h18, 32'h2000, 32'h2000);
    rc(`MSC_A_CSR, 32'h80, 32'h0);
    fwd_lim <= 4'h2;
    repeat (3) @(posedge clk);
    cmd(`MSC_OP_FINDINDEX, 2'h2, 32'h0);
    rc(8'h18, 32'h2000, 32'h0);
    cmd(`MSC_OP_START, 2'h1, 32'h0);
    rc(8'h14, 32'h2000, 32'h2000);
    fwd_lim <= 4'h0;
  endtask
  task automatic t_check();
    cmd(`MSC_OP_FINDHOME, 2'h2, 32'h0);
    rc(8'h18, 32'h2000, 32'h2000);
    ax_lim_home_en <= 4'hF;
    cmd(`MSC_OP_FINDHOME, 2'h2, 32'h0);
    rc(8'h18, 32'h2000, 32'h0);
    ax_trig_en <= 4'h1;
    cmd(`MSC_OP_FINDHOME, 2'h2, 32'h0);
    rc(8'h18, 32'h2000, 32'h2000);
    ax_trig_en <= 4'h0;
    fwd_lim <= 4'h4;
    rev_lim <= 4'h4;
    cmd(`MSC_OP_FINDHOME, 2'h2, 32'h0);
    rc(8'h18, 32'h2000, 32'h2000);
    rev_lim <= 4'h0;
    fwd_lim <= 4'h2;
    cmd(`MSC_OP_MSTART, 2'h0, 32'h3);
    rc(8'h14, 32'h2000, 32'h2000);
    fwd_lim <= 4'h0;
    cmd(`MSC_OP_BPTIME, 2'h2, 32'h1F);
    rc(8'h18, 32'h2000, 32'h2000);
    cmd(`MSC_OP_BPTIME, 2'h2, 32'h20);
    rc(8'h18, 32'h2000, 32'h0);
    ax_accel_high <= 4'h4;
    cmd(`MSC_OP_BPTIME, 2'h2, 32'h20);
    rc(8'h18, 32'h2000, 32'h2000);
    ax_accel_high <= 4'h0;
    cmd(`MSC_OP_BPTIME, 2'h0, 32'h20);
    rc(8'h10, 32'h2000, 32'h2000);
    cmd(`MSC_OP_BPPOS, 2'h2, 32'h0);
    rc(8'h18, 32'h2000, 32'h2000);
    cmd(`MSC_OP_BPPOS, 2'h2, 32'h5);
    rc(8'h18, 32'h2000, 32'h0);
    cmd(`MSC_OP_BPPOS, 2'h2, 32'h80000000);
    rc(8'h18, 32'h2000, 32'h2000);
    ax_fwd <= 4'h1;
    rc(8'h10, 32'h1000, 32'h1000);
  endtask
  task automatic t_csr();
    cmd(`MSC_OP_MSTART, 2'h0, 32'h1);
    rc(`MSC_A_CSR, 32'h98, 32'h10);
    cmd(`MSC_OP_RSTPOS, 2'h0, 32'h0);
    rc(`MSC_A_CSR, 32'h20, 32'h0);
    watchdog <= 1'h1;
    rdb_pending <= 1'h1;
    msc_host_inst.wr(`MSC_A_HWFAIL, 32'h1, rsp);
    watchdog <= 1'h0;
    rc(`MSC_A_CSR, 32'h62, 32'h62);
    msc_host_inst.rd(8'h3C, rv, rsp);
    chk({30'h0, rsp}, {30'h0, `MSC_RESP_SLV});
    msc_host_inst.wr(8'h3C, 32'h0, rsp);
    chk({30'h0, rsp}, {30'h0, `MSC_RESP_SLV});
  endtask
  initial
  begin
    {ax_running, ax_velmode, ax_fwd, ax_pcomp, ax_poserr, ax_wrap} = '0;
    {ax_index, ax_motor_off, ax_homing, ax_lim_home_en, ax_trig_en} = '0;
    {ax_accel_high, home_sw, fwd_lim, rev_lim, rdb_pending, watchdog} = '0;
    repeat (8) @(posedge clk);
    reset <= 1'h0;
    @(posedge clk);
    rc(`MSC_A_CSR, 32'hFFFFFFFF, 32'h000000A1);
    t_stat();
    t_adc();
    t_mode();
    t_switch();
    t_check();
    t_csr();
    conclude();
  end
  initial
  begin
    #400000;
    error_cnt++;
    conclude();
  end
endmodule // msc_top_tb
